/* design/srss_cfg.svh */
// Purpose: Constants of the serial ROM slave front end
// Assumes: Included by its bare name
// Notes: Opcodes, widths and counts only
`ifndef SRSS_CFG_SVH
`define SRSS_CFG_SVH
`define SRSS_OP_READ 8'h03
`define SRSS_OP_FAST 8'h0b
`define SRSS_ADDR_BITS 21
`define SRSS_ADDR_BYTES 3
`define SRSS_FIFO_DEPTH 8
`define SRSS_STBY_CYCLES 4
`endif

/* design/srss_pkg.sv */
// Purpose: Types of the serial ROM slave front end
// Assumes: Nothing
// Notes: Phase states of one selected sequence
package srss_pkg;
  typedef enum logic [2:0] {
    SRSS_IDLE, SRSS_CMD, SRSS_ADDR, SRSS_DUMMY, SRSS_DATA, SRSS_BAD
  } srss_phase_t;
endpackage

/* design/srss_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active high reset
// Notes: Full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module srss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH)) && !flush_i;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rd_q];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // srss_fifo
`default_nettype wire

/* design/srss_slave.sv */
// Purpose: SPI slave front end of a serial read-only memory with pause
// Assumes: Pins sampled by core_clk_i, serial clock far slower than it
// Notes: ROM words arrive by request/answer through an 8-word FIFO
// Operation
// - Output bit changes after serial clock falls
// - Input bits captured on serial clock rise
// - Select high ignores bus; low activates
// - Decode only after a seen select fall
// - Active while selected; standby after internal cycles
// - Clock idles low or high, same edges
// - Pause starts on fall, clock low qualifies
// - Pause ends on rise, clock low qualifies
// - Pause floats output, freezes shift state
// - Deselect during pause resets interface
// - Opcode, address, data all MSB first
// - 03h three address; 0Bh adds dummy
// - Address increments per byte, wraps, top ignored
// - Select rise ends read, output stops
`timescale 1ns/1ps
`default_nettype none
`include "srss_cfg.svh"
module srss_slave (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Serial pins
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic pause_n_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  // ROM fetch port
  output logic rom_req_valid_o,
  input wire logic rom_req_ready_i,
  output logic [`SRSS_ADDR_BITS-1:0] rom_req_addr_o,
  input wire logic rom_rsp_valid_i,
  output logic rom_rsp_ready_o,
  input wire logic [7:0] rom_rsp_data_i,
  // Power state
  output logic active_o
);
  import srss_pkg::*;
  // Two-flop synchronisers
  logic [1:0] cs_s_q, ck_s_q, di_s_q, pz_s_q;
  logic cs_q, ck_q, pz_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_s_q <= 2'h3;
      ck_s_q <= 2'h0;
      di_s_q <= 2'h0;
      pz_s_q <= 2'h3;
      cs_q <= 1'b1;
      ck_q <= 1'b0;
      pz_q <= 1'b1;
    end else begin
      cs_s_q <= {cs_s_q[0], chip_select_n_i};
      ck_s_q <= {ck_s_q[0], sclk_i};
      di_s_q <= {di_s_q[0], mosi_i};
      pz_s_q <= {pz_s_q[0], pause_n_i};
      cs_q <= cs_s_q[1];
      ck_q <= ck_s_q[1];
      pz_q <= pz_s_q[1];
    end
  end
  wire cs_n = cs_s_q[1];
  wire ck = ck_s_q[1];
  wire din = di_s_q[1];
  wire pz_n = pz_s_q[1];
  wire cs_fall = cs_q && !cs_n;
  wire ck_rise = !ck_q && ck;
  wire ck_fall = ck_q && !ck;
  // Pause tracking
  logic paused_q, armed_q;
  wire pause_want = !pz_n && !cs_n;
  wire pause_go = !paused_q && pause_want && !ck;
  wire pause_end = paused_q && pz_n && !ck;
  wire live = !paused_q && !pause_go;
  wire cs_rise_in_pause = !cs_q && cs_n && paused_q;
  // Sequence state
  srss_phase_t phase_q, phase_d;
  logic [2:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  logic [7:0] out_q;
  logic fast_q, drive_q, miso_q;
  logic [`SRSS_ADDR_BITS-1:0] addr_q;
  logic [2:0] stby_q;
  wire [7:0] sh_next = {sh_q[6:0], din};
  wire byte_done = ck_rise && live && (bit_q == 3'h7);
  wire start_data = byte_done && (
    (phase_q == SRSS_DUMMY) ||
    (phase_q == SRSS_ADDR && byte_q == 2'h2 && !fast_q));
  // Fetch path through the FIFO
  logic req_pend_q;
  logic [7:0] f_data;
  logic f_valid, f_in_ready, f_pop;
  wire flush = cs_n;
  assign rom_req_valid_o = req_pend_q;
  assign rom_req_addr_o = addr_q;
  assign f_pop = (phase_q == SRSS_DATA) && live && ck_fall &&
    (bit_q == 3'h0) && f_valid;
  srss_fifo #(.WIDTH(8), .DEPTH(`SRSS_FIFO_DEPTH)) srss_fifo_i (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .in_valid_i(rom_rsp_valid_i),
    .in_ready_o(f_in_ready),
    .in_data_i(rom_rsp_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );
  // Answers still in flight at deselect are taken and dropped
  assign rom_rsp_ready_o = f_in_ready || flush;
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      SRSS_IDLE: if (armed_q && !cs_n) phase_d = SRSS_CMD;
      SRSS_CMD: if (byte_done) begin
        if (sh_next == `SRSS_OP_READ || sh_next == `SRSS_OP_FAST) begin
          phase_d = SRSS_ADDR;
        end else begin
          phase_d = SRSS_BAD;
        end
      end
      SRSS_ADDR: if (byte_done && byte_q == 2'h2) begin
        phase_d = fast_q ? SRSS_DUMMY : SRSS_DATA;
      end
      SRSS_DUMMY: if (byte_done) phase_d = SRSS_DATA;
      SRSS_DATA: phase_d = SRSS_DATA;
      SRSS_BAD: phase_d = SRSS_BAD;
      default: phase_d = SRSS_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      paused_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      if (cs_fall && pz_n) armed_q <= 1'b1;
      else if (cs_rise_in_pause) armed_q <= 1'b0;
      if (cs_n) paused_q <= 1'b0;
      else if (pause_go) paused_q <= 1'b1;
      else if (pause_end) paused_q <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= SRSS_IDLE;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
      fast_q <= 1'b0;
      addr_q <= '0;
      req_pend_q <= 1'b0;
    end else if (cs_n) begin
      phase_q <= SRSS_IDLE;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      req_pend_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      if (ck_rise && live && phase_q != SRSS_BAD &&
          phase_q != SRSS_IDLE && phase_q != SRSS_DATA) begin
        sh_q <= sh_next;
        bit_q <= bit_q + 3'h1;
      end
      if (phase_q == SRSS_DATA && ck_fall && live) begin
        bit_q <= bit_q + 3'h1;
      end
      if (byte_done && phase_q == SRSS_CMD) begin
        fast_q <= (sh_next == `SRSS_OP_FAST);
      end
      if (byte_done && phase_q == SRSS_ADDR) begin
        byte_q <= byte_q + 2'h1;
        addr_q <= {addr_q[`SRSS_ADDR_BITS-9:0], sh_next};
      end
      if (req_pend_q && rom_req_ready_i) begin
        req_pend_q <= 1'b0;
        addr_q <= addr_q + 1'b1;
      end else if (start_data || (f_pop && !req_pend_q)) begin
        req_pend_q <= 1'b1;
      end
    end
  end
  // Output launch on serial clock fall
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= 8'h00;
      miso_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (cs_n) begin
      drive_q <= 1'b0;
      miso_q <= 1'b0;
    end else if (phase_q == SRSS_DATA && ck_fall && live) begin
      drive_q <= 1'b1;
      if (bit_q == 3'h0) begin
        out_q <= {f_data[6:0], 1'b0};
        miso_q <= f_data[7];
      end else begin
        out_q <= {out_q[6:0], 1'b0};
        miso_q <= out_q[7];
      end
    end
  end
  // Power state
  wire busy = req_pend_q || f_valid;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stby_q <= 3'h0;
    end else if (!cs_n || busy) begin
      stby_q <= 3'(`SRSS_STBY_CYCLES);
    end else if (stby_q != 3'h0) begin
      stby_q <= stby_q - 3'h1;
    end
  end
  assign active_o = !cs_n || (stby_q != 3'h0);
  assign miso_o = miso_q;
  assign miso_oe_n_o = !(drive_q && !paused_q && !cs_n);
endmodule // srss_slave
`default_nettype wire

/* bench/srss_monitor.sv */
// Purpose: Pin checks of the serial ROM slave
// Assumes: Bound to srss_slave
// Notes: Bounds allow for pin synchronisation
`timescale 1ns/1ps
`default_nettype none
module srss_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Watched pins
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic pause_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_n_o,
  input wire logic rom_req_valid_o,
  input wire logic active_o
);
  logic [5:0] rise_q;
  logic [3:0] fall_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rise_q <= '0;
      fall_q <= 4'hf;
    end else begin
      if (chip_select_n_i) rise_q <= '0;
      else if ($rose(sclk_i) && rise_q != 6'h3f) rise_q <= rise_q + 6'h1;
      if ($fell(sclk_i)) fall_q <= '0;
      else if (fall_q != 4'hf) fall_q <= fall_q + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_float_desel: assert property (chip_select_n_i[*5] |-> miso_oe_n_o)
    else $error("output driven while deselected");
  a_pause_float: assert property ((!pause_n_i && !sclk_i)[*6] |->
    miso_oe_n_o) else $error("output driven while paused");
  a_active_sel: assert property (!chip_select_n_i[*5] |-> active_o)
    else $error("not active while selected");
  a_standby_end: assert property (chip_select_n_i[*8] |->
    ##[0:40] !active_o) else $error("standby not reached");
  a_launch_fall: assert property ($changed(miso_o) && !miso_oe_n_o &&
    !$past(miso_oe_n_o) |-> fall_q < 4'h8) else $error("output not on fall");
  a_recv_float: assert property ($fell(miso_oe_n_o) |->
    rise_q >= 6'h20) else $error("output driven during header");
  a_req_late: assert property ($rose(rom_req_valid_o) |->
    rise_q >= 6'h20) else $error("fetch before address complete");
  a_desel_noreq: assert property (chip_select_n_i[*6] |->
    !$rose(rom_req_valid_o)) else $error("fetch while deselected");
endmodule // srss_monitor
bind srss_slave srss_monitor srss_monitor_i (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .chip_select_n_i(chip_select_n_i), .sclk_i(sclk_i),
  .pause_n_i(pause_n_i), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
  .rom_req_valid_o(rom_req_valid_o), .active_o(active_o));
`default_nettype wire

/* bench/srss_rom_model.sv */
// Purpose: ROM behind the fetch port
// Assumes: One fetch at a time
// Notes: Byte is address low byte plus bits 20..16
`timescale 1ns/1ps
`default_nettype none
module srss_rom_model #(
  parameter int LAT = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fetch port
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [20:0] req_addr_i,
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [7:0] rsp_data_o
);
  logic [3:0] cnt_q;
  logic busy_q;
  logic [7:0] val_q;
  assign req_ready_o = !busy_q;
  assign rsp_valid_o = busy_q && cnt_q == 4'h0;
  assign rsp_data_o = rsp_valid_o ? val_q : ~val_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      val_q <= 8'h00;
    end else if (!busy_q && req_valid_i) begin
      busy_q <= 1'b1;
      cnt_q <= 4'(LAT);
      val_q <= req_addr_i[7:0] + {3'h0, req_addr_i[20:16]};
    end else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    else if (rsp_ready_i) busy_q <= 1'b0;
  end
endmodule // srss_rom_model
`default_nettype wire

/* bench/serial_rom_spi_slave_hold_tb.sv */
// Purpose: Self-checking bench of the serial ROM slave
// Assumes: Master in modes 0 and 3, serial clock 64 ns
// Notes: Master samples data late in the clock high phase
`timescale 1ns/1ps
`default_nettype none
`include "srss_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  n_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module serial_rom_spi_slave_hold_tb;
  logic core_clk_i = 0, rst_i = 1, cs_n = 1, sclk = 0, mosi = 0;
  logic pause_n = 1, cpol = 0, miso, oe_n, rq_v, rq_r, rs_v, rs_r, act;
  logic [20:0] rq_a;
  logic [7:0] rs_d;
  int n_errors = 0, samples_checked = 0, n_req = 0;
  always #4 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) if (rq_v && rq_r) n_req++;
  srss_slave srss_slave_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .chip_select_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
    .pause_n_i(pause_n), .miso_o(miso), .miso_oe_n_o(oe_n),
    .rom_req_valid_o(rq_v), .rom_req_ready_i(rq_r), .rom_req_addr_o(rq_a),
    .rom_rsp_valid_i(rs_v), .rom_rsp_ready_o(rs_r),
    .rom_rsp_data_i(rs_d), .active_o(act));
  srss_rom_model srss_rom_model_i (.clk_i(core_clk_i), .rst_i(rst_i),
    .req_valid_i(rq_v), .req_ready_o(rq_r), .req_addr_i(rq_a),
    .rsp_valid_o(rs_v), .rsp_ready_i(rs_r), .rsp_data_o(rs_d));
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic byte_x(input logic [7:0] b, input logic drv,
                        output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sclk = 0;
      mosi = b[i];
      cyc(4);
      sclk = 1;
      cyc(4);
      r[i] = miso;
      `CHK(oe_n, !drv)
    end
  endtask
  task automatic start(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] r;
    cs_n = 0;
    cyc(4);
    byte_x(op, 0, r);
    for (int i = 2; i >= 0; i--) byte_x(a[8*i+:8], 0, r);
    if (op == `SRSS_OP_FAST) byte_x(8'h00, 0, r);
  endtask
  task automatic rd(input logic [20:0] a, input int n);
    logic [7:0] r;
    for (int k = 0; k < n; k++) begin
      byte_x(8'hff, 1, r);
      `CHK(r, 8'(a + 21'(k)) + {3'h0, 5'((a + 21'(k)) >> 16)})
    end
  endtask
  task automatic stop;
    cyc(4);
    sclk = cpol;
    cyc(4);
    cs_n = 1;
    cyc(12);
  endtask
  task automatic sc_read_wrap;
    start(`SRSS_OP_READ, 24'hfffffe);
    rd(21'h1ffffe, 4);
    `CHK(act, 1'b1)
    stop;
    cyc(40);
    `CHK(act, 1'b0)
  endtask
  task automatic sc_fast_mode3;
    cpol = 1;
    sclk = 1;
    cyc(8);
    start(`SRSS_OP_FAST, 24'h0123f0);
    rd(21'h0123f0, 2);
    stop;
    cpol = 0;
    sclk = 0;
  endtask
  task automatic sc_bad_op;
    logic [7:0] r;
    int n0;
    n0 = n_req;
    start(8'h5a, 24'h000000);
    byte_x(8'h00, 0, r);
    `CHK(n_req, n0)
    stop;
  endtask
  task automatic sc_pause;
    logic [7:0] r;
    start(`SRSS_OP_READ, 24'h000040);
    rd(21'h000040, 1);
    sclk = 0;
    cyc(6);
    pause_n = 0;
    cyc(8);
    byte_x(8'h0f, 0, r);
    sclk = 0;
    cyc(6);
    pause_n = 1;
    cyc(8);
    rd(21'h000041, 1);
    stop;
  endtask
  task automatic sc_desel_pause;
    start(`SRSS_OP_READ, 24'h000100);
    sclk = 0;
    cyc(6);
    pause_n = 0;
    cyc(8);
    cs_n = 1;
    cyc(12);
    pause_n = 1;
    cyc(4);
    start(`SRSS_OP_READ, 24'h000200);
    rd(21'h000200, 2);
    stop;
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst_i = 0;
    cyc(4);
    sc_read_wrap;
    sc_fast_mode3;
    sc_bad_op;
    sc_pause;
    sc_desel_pause;
    conclude;
  end
  initial begin
    #200us;
    n_errors++;
    conclude;
  end
endmodule // serial_rom_spi_slave_hold_tb
`default_nettype wire
